// [logic/drc_reset_control.sv]
// reset, clear-code and update control with 24-bit serial word intake
`timescale 1ns/1ns

module drc_reset_control
  import drc_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          serialClk,
  input  wire logic                          serialData,
  input  wire logic                          frameSelN,
  input  wire logic                          clearN,
  input  wire logic                          load_update_n,
  input  wire logic                          clear_level_select,
  output logic [drc_pkg::NCH-1:0][drc_pkg::DATA_W-1:0] channel_output,
  output logic                               initDone,
  output logic                               wordStrobe
);
  import drc_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    drc_sync_s                          sync;
    drc_state_e                         state;
    logic [WORD_W-1:0]                  shift;
    logic [BITCNT_W-1:0]                bitCnt;
    logic [NCH-1:0][DATA_W-1:0]         inReg;
    logic [NCH-1:0][DATA_W-1:0]         outReg;
    logic [NCH-1:0]                     ldMask;
    logic [DATA_W-1:0]                  porCode;
    logic                               strobe;
    // registered copy of "left uninit" so the port comes from a flop
    logic                               ready;
  } drc_state_s;

  drc_state_s stQ;
  drc_state_s stD;

  // only the second and third stages feed logic
  drc_link_s  link;
  drc_link_s  linkPrev;
  logic       clrLow;
  logic       loadLow;
  logic       loadFall;
  logic       frameRise;
  logic       sclkRise;
  logic       wordOk;
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [DATA_W-1:0] dataField;
  logic [DATA_W-1:0] selCode;

  assign link      = '{sclk: stQ.sync.sclk[1], sdin: stQ.sync.sdin[1],
                       frameN: stQ.sync.frameN[1]};
  assign linkPrev  = '{sclk: stQ.sync.sclk[2], sdin: stQ.sync.sdin[2],
                       frameN: stQ.sync.frameN[2]};
  assign clrLow    = ~stQ.sync.clearN[1];
  assign loadLow   = ~stQ.sync.loadN[1];
  assign loadFall  = stQ.sync.loadN[2] & ~stQ.sync.loadN[1];
  assign sclkRise  = link.sclk & ~linkPrev.sclk;
  assign frameRise = link.frameN & ~linkPrev.frameN;
  // word valid only with exactly 24 bits
  assign wordOk    = frameRise && (stQ.bitCnt == WORD_BITS);
  assign cmd       = stQ.shift[CMD_MSB:CMD_LSB];
  assign addr      = stQ.shift[ADDR_MSB:ADDR_LSB];
  assign dataField = stQ.shift[DATA_MSB:0];
  assign selCode   = stQ.sync.levelSel[1] ? MID_CODE : ZERO_CODE;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    stD = stQ;
    stD.strobe = 1'b0;
    stD.sync.sclk     = {stQ.sync.sclk[1:0], serialClk};
    stD.sync.sdin     = {stQ.sync.sdin[1:0], serialData};
    stD.sync.frameN   = {stQ.sync.frameN[1:0], frameSelN};
    stD.sync.clearN   = {stQ.sync.clearN[1:0], clearN};
    stD.sync.loadN    = {stQ.sync.loadN[1:0], load_update_n};
    stD.sync.levelSel = {stQ.sync.levelSel[0], clear_level_select};

    // serial shift, counting saturates at 31
    if (link.frameN) begin
      stD.bitCnt = '0;
    end else if (sclkRise) begin
      stD.shift = {stQ.shift[WORD_W-2:0], link.sdin};
      if (stQ.bitCnt != 5'h1F) begin
        stD.bitCnt = stQ.bitCnt + 5'h01;
      end
    end

    case (stQ.state)
      ST_UNINIT: begin
        // wait for clear release before init
        if (!clrLow) begin
          stD.porCode = selCode;
          for (int i = 0; i < NCH; i++) begin
            stD.inReg[i]  = selCode;
            stD.outReg[i] = selCode;
          end
          stD.ldMask = '0;
          stD.state  = ST_RUN;
        end
      end
      ST_RUN: begin
        if (clrLow) begin
          for (int i = 0; i < NCH; i++) begin
            stD.outReg[i] = selCode;
          end
          stD.state = ST_CLEAR;
        end else begin
          if (wordOk) begin
            stD.strobe = 1'b1;
            case (cmd)
              CMD_WR_IN, CMD_WR_UPD: begin
                for (int i = 0; i < NCH; i++) begin
                  if (addr[i]) begin
                    stD.inReg[i] = dataField;
                    // output moves on write-and-update, or on plain write with load held low
                    if (cmd == CMD_WR_UPD || loadLow) begin
                      stD.outReg[i] = dataField;
                    end
                  end
                end
              end
              CMD_UPD: begin
                for (int i = 0; i < NCH; i++) begin
                  if (addr[i]) begin
                    stD.outReg[i] = stQ.inReg[i];
                  end
                end
              end
              CMD_LMASK: begin
                stD.ldMask = stQ.shift[NCH-1:0];
              end
              CMD_SWRST: begin
                for (int i = 0; i < NCH; i++) begin
                  stD.inReg[i]  = stQ.porCode;
                  stD.outReg[i] = stQ.porCode;
                end
                stD.ldMask = '0;
              end
              default: begin
              end
            endcase
          end else if (loadFall) begin
            for (int i = 0; i < NCH; i++) begin
              if (!stQ.ldMask[i]) begin
                stD.outReg[i] = stQ.inReg[i];
              end
            end
          end
        end
      end
      ST_CLEAR: begin
        for (int i = 0; i < NCH; i++) begin
          stD.outReg[i] = selCode;
        end
        if (!clrLow) begin
          stD.state = ST_RUN;
        end
      end
      default: begin
        stD.state = ST_UNINIT;
      end
    endcase
    stD.ready = (stD.state != ST_UNINIT);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // load-update ignored: reset state holds no edge history
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stQ <= '{sync: '{sclk: 3'h0, sdin: 3'h0, frameN: 3'h7, clearN: 3'h0,
                      loadN: 3'h7, levelSel: 2'h0},
               state: ST_UNINIT, shift: '0, bitCnt: '0, inReg: '0,
               outReg: '0, ldMask: '0, porCode: '0, strobe: 1'b0,
               ready: 1'b0};
    end else begin
      stQ <= stD;
    end
  end

  assign channel_output = stQ.outReg;
  assign initDone       = stQ.ready;
  assign wordStrobe     = stQ.strobe;
endmodule : drc_reset_control

// [logic/drc_pkg.sv]
// shared constants and types for the converter reset and update control
package drc_pkg;
  localparam int DATA_W = 16;
  localparam int NCH = 4;
  localparam int WORD_W = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int BITCNT_W = 5;
  localparam logic [4:0] WORD_BITS = 5'h18;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_IN = 4'h1;
  localparam logic [3:0] CMD_UPD = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_PDOWN = 4'h4;
  localparam logic [3:0] CMD_LMASK = 4'h5;
  localparam logic [3:0] CMD_SWRST = 4'h6;
  // least clear pulse width and its count at 25 MHz
  localparam int CLR_MIN_NS = 30;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLR_MIN_CYC = (CLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [DATA_W-1:0] ZERO_CODE = 16'h0000;
  localparam logic [DATA_W-1:0] MID_CODE = 16'h8000;

  typedef enum logic [1:0] {
    ST_UNINIT = 2'b00,
    ST_RUN    = 2'b01,
    ST_CLEAR  = 2'b10
  } drc_state_e;

  // synchronised link pins
  typedef struct packed {
    logic sclk;
    logic sdin;
    logic frameN;
  } drc_link_s;

  typedef struct packed {
    logic [2:0] sclk;
    logic [2:0] sdin;
    logic [2:0] frameN;
    logic [2:0] clearN;
    logic [2:0] loadN;
    logic [1:0] levelSel;
  } drc_sync_s;
endpackage : drc_pkg

// [dv/drc_reset_control_sva.sv]
// port assertions for the reset control block
`timescale 1ns/1ns
module drc_reset_control_sva
  import drc_pkg::*;
(
  input wire logic                                        clock,
  input wire logic                                        nrst,
  input wire logic                                        frameSelN,
  input wire logic                                        clearN,
  input wire logic                                        load_update_n,
  input wire logic                                        clear_level_select,
  input wire logic [drc_pkg::NCH-1:0][drc_pkg::DATA_W-1:0] channel_output,
  input wire logic                                        initDone,
  input wire logic                                        wordStrobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // long enough for the synchronisers to settle
  sequence sClr;
    (!clearN && $stable(clear_level_select))[*5];
  endsequence
  sequence sQuiet;
    initDone ##0 (clearN && load_update_n)[*6];
  endsequence
  AST_UNINIT_HOLD: assert property ((!clearN)[*4] ##0 !initDone |=> !initDone)
    else $error("init while clear low");
  AST_QUIET: assert property (!initDone |-> channel_output == '0 && !wordStrobe)
    else $error("activity while uninitialised");
  AST_CLEAR_CODE: assert property (sClr ##0 initDone |->
    channel_output == {NCH{clear_level_select ? MID_CODE : ZERO_CODE}})
    else $error("wrong clear code");
  AST_CLEAR_REFUSE: assert property ((!clearN)[*6] |-> !wordStrobe)
    else $error("word taken during clear");
  AST_HOLD: assert property (sQuiet ##0 !wordStrobe |-> $stable(channel_output))
    else $error("output moved without cause");
  AST_POR_CODE: assert property ($rose(initDone) |->
    channel_output == {NCH{clear_level_select ? MID_CODE : ZERO_CODE}})
    else $error("wrong power-on code");
  AST_FRAME: assert property (wordStrobe |-> $past(frameSelN, 3) && !$past(frameSelN, 6))
    else $error("strobe not after frame rise");
  AST_PULSE: assert property (wordStrobe |=> !wordStrobe)
    else $error("strobe longer than one cycle");
endmodule : drc_reset_control_sva

bind drc_reset_control drc_reset_control_sva drc_reset_control_sva_inst (.clock, .nrst,
  .frameSelN, .clearN, .load_update_n, .clear_level_select, .channel_output, .initDone,
  .wordStrobe);

// [dv/drc_host_model.sv]
// host serial port model driving the link pins
`timescale 1ns/1ns
module drc_host_model (
  input  wire logic clock,
  output logic      serialClk,
  output logic      serialData,
  output logic      frameSelN
);
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    frameSelN = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : tick
  // msb-first word, four clocks per serial half period
  task automatic send(input logic [23:0] w, input int n);
    tick(1);
    frameSelN = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      serialData = w[i];
      tick(4);
      serialClk = 1'b1;
      tick(4);
      serialClk = 1'b0;
    end
    tick(4);
    frameSelN = 1'b1;
    // released line must not keep the last bit
    serialData = ~serialData;
    tick(4);
  endtask : send
endmodule : drc_host_model

// [dv/drc_reset_control_bench.sv]
// self-checking bench for the reset control block
`timescale 1ns/1ns
module drc_reset_control_bench;
  import drc_pkg::*;
  logic clock, nrst, clearN, load_update_n, clear_level_select;
  logic serialClk, serialData, frameSelN, initDone, wordStrobe;
  logic [NCH-1:0][DATA_W-1:0] chOut;
  int errors, nCompared;
  drc_reset_control drc_reset_control_inst (.clock, .nrst, .serialClk, .serialData,
    .frameSelN, .clearN, .load_update_n, .clear_level_select, .channel_output(chOut),
    .initDone, .wordStrobe);
  drc_host_model drc_host_model_inst (.clock, .serialClk, .serialData, .frameSelN);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : cyc
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rst(input logic s);
    nrst = 1'b0;
    clear_level_select = s;
    cyc(3);
    nrst = 1'b1;
    cyc(8);
  endtask : rst
  task automatic wr(input logic [23:0] w);
    drc_host_model_inst.send(w, 24);
    cyc(2);
  endtask : wr
  task automatic test_done();
    $display("errors %0d compared %0d", errors, nCompared);
    if (errors == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por();
    for (int s = 0; s < 2; s++) begin
      rst(s[0]);
      check(chOut, {NCH{s ? MID_CODE : ZERO_CODE}});
    end
  endtask : t_por
  task automatic t_word();
    wr({CMD_WR_UPD, 4'h5, 16'h1234});
    check(chOut, {MID_CODE, 16'h1234, MID_CODE, 16'h1234});
    drc_host_model_inst.send({CMD_WR_UPD, 4'hF, 16'hAAAA}, 23);
    cyc(2);
    check(chOut, {MID_CODE, 16'h1234, MID_CODE, 16'h1234});
  endtask : t_word
  task automatic t_defer();
    wr({CMD_WR_IN, 4'h2, 16'h5678});
    check(chOut, {MID_CODE, 16'h1234, MID_CODE, 16'h1234});
    load_update_n = 1'b0;
    cyc(8);
    load_update_n = 1'b1;
    check(chOut, {MID_CODE, 16'h1234, 16'h5678, 16'h1234});
    wr({CMD_SWRST, 20'h0});
    check(chOut, {NCH{MID_CODE}});
  endtask : t_defer
  task automatic t_clear();
    // clear held six cycles and then through a whole word, well over the least width
    clearN = 1'b0;
    clear_level_select = 1'b0;
    cyc(6);
    check(chOut, {NCH{ZERO_CODE}});
    wr({CMD_WR_UPD, 4'hF, 16'h1111});
    check(chOut, {NCH{ZERO_CODE}});
    clearN = 1'b1;
    cyc(6);
    check(chOut, {NCH{ZERO_CODE}});
    wr({CMD_WR_UPD, 4'hF, 16'h2222});
    check(chOut, {NCH{16'h2222}});
  endtask : t_clear
  task automatic t_uninit();
    clearN = 1'b0;
    rst(1'b1);
    load_update_n = 1'b0;
    cyc(6);
    load_update_n = 1'b1;
    check({63'h0, initDone}, 64'h0);
    check(chOut, 64'h0);
    clearN = 1'b1;
    cyc(8);
    check(chOut, {NCH{MID_CODE}});
  endtask : t_uninit
  initial begin
    nrst = 1'b0;
    clearN = 1'b1;
    load_update_n = 1'b1;
    clear_level_select = 1'b1;
    errors = 0;
    nCompared = 0;
    t_por();
    t_word();
    t_defer();
    t_clear();
    t_uninit();
    test_done();
  end
  // six words of some 200 cycles each, with a wide margin
  initial begin
    #400000;
    errors++;
    test_done();
  end
endmodule : drc_reset_control_bench
